// ---- hw/fws_pkg.sv ----
package fws_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  // ----------------------------------------------------------------
  // Status bit positions on the data bus
  // ----------------------------------------------------------------
  localparam int BIT_POLL  = 7;
  localparam int BIT_TOG1  = 6;
  localparam int BIT_TOUT  = 5;
  localparam int BIT_ETMR  = 3;
  localparam int BIT_TOG2  = 2;
  localparam int BIT_BABRT = 1;
  // ----------------------------------------------------------------
  // Commands from the user port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FWS_CMD_POLL   = 2'h0,
    FWS_CMD_ADDSEC = 2'h1,
    FWS_CMD_RESET  = 2'h2,
    FWS_CMD_BABRT  = 2'h3
  } fws_cmd_e;
  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  localparam logic [2:0] RES_DONE     = 3'h0;
  localparam logic [2:0] RES_TIMEOUT  = 3'h1;
  localparam logic [2:0] RES_ABORT    = 3'h2;
  localparam logic [2:0] RES_REJECTED = 3'h3;
  localparam logic [2:0] RES_ACCEPTED = 3'h4;
  // ----------------------------------------------------------------
  // Timing: 10 MHz clock, 100 ns period
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 100;
  localparam int RD_STROBE_NS   = 200;
  localparam int RD_STROBE_CYC  = (RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_STROBE_NS   = 100;
  localparam int WR_STROBE_CYC  = (WR_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADD_GAP_US     = 50;
  localparam int ADD_GAP_CYC    = (ADD_GAP_US * 1000) / CLK_NS;
  localparam int CNT_W          = 10;
  // Unlock and command words of the buffer-abort reset sequence, and the sector erase command
  localparam logic [ADDR_W-1:0] UNLK_A1 = 24'h000555;
  localparam logic [ADDR_W-1:0] UNLK_A2 = 24'h0002AA;
  localparam logic [DATA_W-1:0] UNLK_D1 = 8'hAA;
  localparam logic [DATA_W-1:0] UNLK_D2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_RST = 8'hF0;
  localparam logic [DATA_W-1:0] CMD_SEC = 8'h30;
endpackage : fws_pkg

// ---- hw/fws_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Request from the sequencer to the bus cycle engine and its answer
interface fws_bus_if;
  import fws_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fws_bus_if
`default_nettype wire

// ---- hw/fws_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
module fws_cycle
  import fws_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Sequencer side
  fws_bus_if.eng                 bus,
  // Flash pins (data already synchronised)
  input  wire logic [DATA_W-1:0] i_dq_sync,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_dq_out,
  output logic                   o_dq_oe,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n
);
  // ----------------------------------------------------------------
  // One strobe per request, data sampled at its end
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic             busy_ff;
  logic             done_ff;
  logic [DATA_W-1:0] rdata_ff;
  wire  [CNT_W-1:0] strobe_len = bus.wr ? CNT_W'(WR_STROBE_CYC) : CNT_W'(RD_STROBE_CYC + 2);
  wire              last     = busy_ff && (cnt_ff == strobe_len);
  assign bus.done  = done_ff;
  assign bus.rdata = rdata_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= '0;
      done_ff <= 1'b0;
      rdata_ff <= '0;
      o_addr  <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
    end else begin
      done_ff <= last;
      if (!busy_ff && bus.req && !done_ff) begin
        busy_ff  <= 1'b1;
        cnt_ff   <= CNT_W'(1);
        o_addr   <= bus.addr;
        o_dq_out <= bus.wdata;
        o_dq_oe  <= bus.wr;
        o_ce_n   <= 1'b0;
        o_oe_n   <= bus.wr;
        o_we_n   <= !bus.wr;
      end else if (last) begin
        busy_ff  <= 1'b0;
        rdata_ff <= i_dq_sync;
        o_dq_oe  <= 1'b0;
        o_ce_n   <= 1'b1;
        o_oe_n   <= 1'b1;
        o_we_n   <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end
endmodule : fws_cycle
`default_nettype wire

// ---- hw/fws_host.sv ----
// Operation
// - Host may skip timer checks if added commands come under 50 us apart.
// - Host confirms acceptance via toggle bit before reading the timer flag; the code reads the timer flag in ST_PRE and ST_POST with no toggle check.
// - Host checks timer flag before and after each added sector erase.
// - After buffer abort host issues the abort reset sequence; the code sends it only on a FWS_CMD_BABRT or FWS_CMD_RESET request.
// - Host presents a valid operation address when polling status.
// - Buffered write status is polled at the last loaded address.
`timescale 1ns/1ps
`default_nettype none
module fws_host
  import fws_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // User command port
  input  wire logic              i_start,
  input  wire logic [1:0]        i_cmd,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  output logic                   o_busy,
  output logic                   o_done,
  output logic [2:0]             o_result,
  output logic [DATA_W-1:0]      o_status,
  output logic                   o_dev_busy,
  // Flash pins
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_ready_busy_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_dq_out,
  output logic                   o_dq_oe,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic              rb_s1_ff, rb_s2_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      rb_s1_ff <= 1'b1;
      rb_s2_ff <= 1'b1;
    end else begin
      dq_s1_ff <= i_dq;
      dq_s2_ff <= dq_s1_ff;
      rb_s1_ff <= i_ready_busy_n;
      rb_s2_ff <= rb_s1_ff;
    end
  end
  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  fws_bus_if bus ();
  fws_cycle u_cycle (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (bus.eng),
    .i_dq_sync (dq_s2_ff),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe   (o_dq_oe),
    .o_ce_n    (o_ce_n),
    .o_oe_n    (o_oe_n),
    .o_we_n    (o_we_n)
  );
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_RD1   = 4'h1,
    ST_RD2   = 4'h3,
    ST_EVAL  = 4'h2,
    ST_CHK   = 4'h6,
    ST_FIN   = 4'h7,
    ST_PRE   = 4'h5,
    ST_WR    = 4'h4,
    ST_POST  = 4'hC,
    ST_SEQ   = 4'hD
  } fws_state_e;
  fws_state_e        state_ff, nxt_state;
  fws_cmd_e          cmd_ff;
  logic [ADDR_W-1:0] op_addr_ff;
  logic [DATA_W-1:0] op_data_ff;
  logic [DATA_W-1:0] first_ff;
  logic [DATA_W-1:0] stat_ff;
  logic              tout_seen_ff;
  logic [1:0]        step_ff;
  logic [2:0]        res_ff;
  logic              is_rd_state;
  logic              is_wr_state;
  // Toggle decode between two status reads
  wire tog1_moving = first_ff[BIT_TOG1] ^ bus.rdata[BIT_TOG1];
  wire tout_now    = bus.rdata[BIT_TOUT];
  wire abort_now   = bus.rdata[BIT_BABRT];
  wire timer_now   = bus.rdata[BIT_ETMR];
  // Three-word abort reset sequence
  wire [ADDR_W-1:0] seq_addr = (step_ff == 2'h1) ? UNLK_A2 : UNLK_A1;
  wire [DATA_W-1:0] seq_data = (step_ff == 2'h0) ? UNLK_D1 :
                               (step_ff == 2'h1) ? UNLK_D2 : CMD_RST;
  assign is_rd_state = (state_ff == ST_RD1) || (state_ff == ST_RD2) ||
                       (state_ff == ST_PRE) || (state_ff == ST_POST);
  assign is_wr_state = (state_ff == ST_WR) || (state_ff == ST_SEQ);
  assign bus.req   = is_rd_state || is_wr_state;
  assign bus.wr    = is_wr_state;
  // Status reads always at the operation address, never a stray one
  assign bus.addr  = (state_ff == ST_SEQ) ? seq_addr : op_addr_ff;
  assign bus.wdata = (state_ff == ST_SEQ) ? seq_data : CMD_SEC;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_start) begin
          case (fws_cmd_e'(i_cmd))
            FWS_CMD_POLL:   nxt_state = ST_RD1;
            FWS_CMD_ADDSEC: nxt_state = ST_PRE;
            default:        nxt_state = ST_SEQ;
          endcase
        end
      end
      ST_RD1:  if (bus.done) nxt_state = ST_RD2;
      ST_RD2:  if (bus.done) begin
        nxt_state = (tog1_moving && !abort_now && tout_now && !tout_seen_ff) ? ST_RD1 : ST_EVAL;
      end
      ST_EVAL: nxt_state = ST_CHK;
      ST_CHK:  nxt_state = ST_FIN;
      // Timer read before every added sector; the spacing shortcut is never relied on
      ST_PRE:  if (bus.done) nxt_state = timer_now ? ST_FIN : ST_WR;
      ST_WR:   if (bus.done) nxt_state = ST_POST;
      ST_POST: if (bus.done) nxt_state = ST_FIN;
      ST_SEQ:  if (bus.done && step_ff == 2'h2) nxt_state = ST_FIN;
      ST_FIN:  nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_ff       <= FWS_CMD_POLL;
      op_addr_ff   <= '0;
      op_data_ff   <= '0;
      first_ff     <= '0;
      stat_ff      <= '0;
      tout_seen_ff <= 1'b0;
      step_ff      <= 2'h0;
      res_ff       <= RES_DONE;
    end else begin
      if (state_ff == ST_IDLE && i_start) begin
        cmd_ff       <= fws_cmd_e'(i_cmd);
        op_addr_ff   <= i_addr;
        op_data_ff   <= i_data;
        tout_seen_ff <= 1'b0;
        step_ff      <= 2'h0;
      end
      if (state_ff == ST_RD1 && bus.done) begin
        first_ff <= bus.rdata;
      end
      if (bus.done && state_ff != ST_SEQ && state_ff != ST_WR) begin
        stat_ff <= bus.rdata;
      end
      if (state_ff == ST_RD2 && bus.done) begin
        // Toggle may stop just as the timeout flag rises, so reread once
        if (!tog1_moving) res_ff <= (bus.rdata == op_data_ff || cmd_ff == FWS_CMD_POLL) ? RES_DONE : RES_DONE;
        else if (abort_now) res_ff <= RES_ABORT;
        else if (tout_now && tout_seen_ff) res_ff <= RES_TIMEOUT;
        else res_ff <= RES_ACCEPTED;
        tout_seen_ff <= tout_now;
      end
      if (state_ff == ST_PRE && bus.done && timer_now) begin
        res_ff <= RES_REJECTED;
      end
      if (state_ff == ST_POST && bus.done) begin
        res_ff <= timer_now ? RES_REJECTED : RES_ACCEPTED;
      end
      if (state_ff == ST_SEQ && bus.done) begin
        step_ff <= step_ff + 2'h1;
        res_ff  <= RES_DONE;
      end
    end
  end
  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_result   <= RES_DONE;
      o_status   <= '0;
      o_dev_busy <= 1'b0;
    end else begin
      o_busy     <= (nxt_state != ST_IDLE);
      o_done     <= (state_ff == ST_FIN);
      o_result   <= (state_ff == ST_FIN) ? res_ff : o_result;
      o_status   <= stat_ff;
      o_dev_busy <= !rb_s2_ff;
    end
  end
endmodule : fws_host
`default_nettype wire

// ---- bench/fws_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Status model of the flash; strobes are sampled on the bench clock
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int WIN = 50
)
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_busy,
  input  wire logic              i_tout,
  input  wire logic              i_abort,
  input  wire logic              i_susp,
  input  wire logic              i_clr,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic              i_ce_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  output logic      [DATA_W-1:0] o_dq,
  output logic                   o_ready_busy_n,
  output var int                 o_wr_cnt
);
  logic              ers_ff = 1'b0, etmr_ff = 1'b0, tog1_ff = 1'b0, tog2_ff = 1'b0;
  logic              abrt_ff = 1'b0, rd_ff = 1'b0, we_ff = 1'b0, hit_ff = 1'b0;
  logic [7:0]        sec_ff = 8'h00;
  logic [DATA_W-1:0] wd_ff = 8'h00, last_ff = 8'h00;
  int                cnt_ff = 0, wr_ff = 0;
  wire               rd = !i_ce_n && !i_oe_n;
  // Suspend keeps the erase pending but lets ready/busy go high
  wire               sus = ers_ff && i_susp;
  wire               bsy = i_busy || (ers_ff && !i_susp);
  wire               in_sec = ers_ff && (i_addr[23:16] == sec_ff);
  wire               pol = sus ? 1'b1 : (ers_ff ? 1'b0 : ~wd_ff[7]);
  wire [DATA_W-1:0]  stat = {pol, tog1_ff, i_tout, 1'b0, etmr_ff, tog2_ff, abrt_ff, 1'b0};
  // A released bus shows the inverse of the last byte, so a late sample is caught
  assign o_dq           = rd ? ((bsy || (sus && in_sec)) ? stat : 8'h00) : ~last_ff;
  assign o_ready_busy_n = !bsy;
  assign o_wr_cnt       = wr_ff;
  always @(posedge i_sys_clk) begin
    rd_ff <= rd;
    we_ff <= !i_we_n;
    if (rd) begin
      last_ff <= o_dq;
      hit_ff  <= in_sec;
    end
    if (rd_ff && !rd && bsy) tog1_ff <= ~tog1_ff;
    if (rd_ff && !rd && hit_ff) tog2_ff <= ~tog2_ff;
    if (i_abort) abrt_ff <= 1'b1;
    if (!i_we_n && !we_ff) begin
      wr_ff    <= wr_ff + 1;
      wd_ff    <= i_dq;
      if (i_dq == CMD_RST) abrt_ff <= 1'b0;
      // Only sector erase opens the window; once closed, sector erase commands are ignored
      if (i_dq == CMD_SEC && !etmr_ff) begin
        ers_ff <= 1'b1;
        cnt_ff <= WIN;
        sec_ff <= i_addr[23:16];
      end
    end else if (ers_ff && !etmr_ff) begin
      if (cnt_ff == 0) etmr_ff <= 1'b1;
      else cnt_ff <= cnt_ff - 1;
    end
    if (i_clr) begin
      ers_ff  <= 1'b0;
      etmr_ff <= 1'b0;
    end
  end
endmodule : fws_flash_model
`default_nettype wire

// ---- bench/fws_host_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fws_host_assertions
  import fws_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              i_start,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_dq_out,
  input wire logic              o_dq_oe,
  input wire logic              o_ce_n,
  input wire logic              o_oe_n,
  input wire logic              o_we_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Set by any read since the request was taken
  logic rd_seen_ff;
  logic nxt_rd_seen;
  assign nxt_rd_seen = (i_start && !o_busy) ? 1'b0 : (rd_seen_ff || !o_oe_n);
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) rd_seen_ff <= 1'b0;
    else rd_seen_ff <= nxt_rd_seen;
  end
  a_status_addr: assert property (!o_ce_n && !o_oe_n |-> o_addr == i_addr)
    else $error("status read at a wrong address");
  a_read_before_cmd: assert property (!o_we_n && o_dq_out == CMD_SEC |-> rd_seen_ff)
    else $error("sector command without a prior status read");
  a_read_after_cmd: assert property ($rose(o_we_n) && $past(o_dq_out) == CMD_SEC |-> ##[1:20] !o_oe_n)
    else $error("no status read after sector command");
  a_rst_cmd_addr: assert property (!o_we_n && o_dq_oe && o_dq_out == CMD_RST |-> o_addr == UNLK_A1)
    else $error("reset command at a wrong address");
  a_unlock_addr: assert property (!o_we_n && o_dq_oe && o_dq_out == UNLK_D2 |-> o_addr == UNLK_A2)
    else $error("second unlock at a wrong address");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_no_contention: assert property (o_dq_oe |-> o_oe_n)
    else $error("host drives data during a read");
  a_start_taken: assert property (i_start && !o_busy |=> o_busy)
    else $error("request not taken");
  a_reset_idle: assert property ($past(i_rst) |-> o_ce_n && o_oe_n && o_we_n && !o_dq_oe)
    else $error("strobes active after reset");
  c_sector_cmd: cover property (!o_we_n && o_dq_out == CMD_SEC);
  c_abort_seq: cover property (!o_we_n && o_dq_out == CMD_RST);
  c_done: cover property (o_done);
endmodule : fws_host_assertions
bind fws_host fws_host_assertions i_fws_host_assertions (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start),
  .i_addr(i_addr), .o_busy(o_busy), .o_done(o_done), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
  .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
`default_nettype wire

// ---- bench/fws_host_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module fws_host_tb;
  import fws_pkg::*;
  typedef struct packed {logic [1:0] cmd; logic busy; logic tout; logic abrt; logic [2:0] res; logic [3:0] nwr;} fws_row_s;
  localparam int WD_CYC = 20000;
  localparam int WIN    = 50;
  logic              i_sys_clk = 1'b0, i_rst, i_start, o_busy, o_done, o_dev_busy, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
  logic              m_busy, m_tout, m_abort, m_clr, m_susp;
  logic [1:0]        i_cmd;
  logic [2:0]        o_result;
  logic [ADDR_W-1:0] i_addr, o_addr;
  logic [DATA_W-1:0] i_data, o_status, o_dq_out, m_dq;
  wire  [DATA_W-1:0] dq_bus = o_dq_oe ? o_dq_out : m_dq;
  wire               rbn;
  int                failures = 0, samples_checked = 0, wr_cnt, base;
  fws_row_s          rows [7] = '{'{FWS_CMD_POLL, 0, 0, 0, RES_DONE, 0}, '{FWS_CMD_POLL, 1, 0, 0, RES_ACCEPTED, 0},
    '{FWS_CMD_POLL, 1, 1, 0, RES_TIMEOUT, 0}, '{FWS_CMD_POLL, 1, 0, 1, RES_ABORT, 0},
    '{FWS_CMD_RESET, 0, 0, 0, RES_DONE, 3}, '{FWS_CMD_POLL, 1, 0, 0, RES_ACCEPTED, 0},
    '{FWS_CMD_BABRT, 0, 0, 0, RES_DONE, 3}};
  always #50 i_sys_clk = ~i_sys_clk;
  fws_host i_fws_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start), .i_cmd(i_cmd), .i_addr(i_addr),
    .i_data(i_data), .o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_status(o_status),
    .o_dev_busy(o_dev_busy), .i_dq(dq_bus), .i_ready_busy_n(rbn), .o_addr(o_addr), .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
  fws_flash_model #(.WIN(WIN)) i_fws_flash_model (.i_sys_clk(i_sys_clk), .i_busy(m_busy), .i_tout(m_tout),
    .i_abort(m_abort), .i_susp(m_susp), .i_clr(m_clr), .i_addr(o_addr), .i_dq(dq_bus), .i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(m_dq), .o_ready_busy_n(rbn), .o_wr_cnt(wr_cnt));
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Issue one request and wait, bounded, for its done pulse
  task automatic run_op(input logic [1:0] c);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    i_cmd = c;
    i_start = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 300) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 300) begin
      failures++;
      $display("[ERR] done_wait expected 1 seen 0");
      close_out;
    end
  endtask : run_op
  initial begin
    {i_rst, i_start, i_cmd, m_busy, m_tout, m_abort, m_clr, m_susp} = 9'h100;
    i_addr = 24'h012345;
    i_data = 8'h5A;
    repeat (20) @(negedge i_sys_clk);
    i_rst = 1'b0;
    `CHK("idle_pins", 6'h38, {o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_busy, o_done})
    $display("test reset done");
    foreach (rows[k]) begin
      {m_busy, m_tout, m_abort} = {rows[k].busy, rows[k].tout, rows[k].abrt};
      repeat (4) @(negedge i_sys_clk);
      base = wr_cnt;
      run_op(rows[k].cmd);
      `CHK("result", rows[k].res, o_result)
      `CHK("writes", rows[k].nwr, 4'(wr_cnt - base))
      `CHK("dev_busy", rows[k].busy, o_dev_busy)
      $display("test row %0d done", k);
    end
    m_busy = 1'b0;
    i_addr = 24'h030000;
    base = wr_cnt;
    run_op(FWS_CMD_ADDSEC);
    `CHK("add_first", RES_ACCEPTED, o_result)
    run_op(FWS_CMD_ADDSEC);
    `CHK("add_again", RES_ACCEPTED, o_result)
    `CHK("add_writes", 2, wr_cnt - base)
    repeat (20) @(negedge i_sys_clk);
    run_op(FWS_CMD_POLL);
    `CHK("window_restart", 1'b0, o_status[BIT_ETMR])
    repeat (WIN) @(negedge i_sys_clk);
    base = wr_cnt;
    run_op(FWS_CMD_ADDSEC);
    `CHK("add_late", RES_REJECTED, o_result)
    `CHK("late_writes", 0, wr_cnt - base)
    `CHK("timer_flag", 1'b1, o_status[BIT_ETMR])
    m_susp = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    run_op(FWS_CMD_POLL);
    `CHK("susp_result", RES_DONE, o_result)
    `CHK("susp_poll", 1'b1, o_status[BIT_POLL])
    `CHK("susp_ready", 1'b0, o_dev_busy)
    m_susp = 1'b0;
    m_clr = 1'b1;
    @(negedge i_sys_clk);
    m_clr = 1'b0;
    $display("test sector window done");
    // Reset in the middle of a status read, then a clean poll
    m_busy = 1'b1;
    @(negedge i_sys_clk);
    i_cmd = FWS_CMD_POLL;
    i_start = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    `CHK("rst_pins", 6'h38, {o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_busy, o_done})
    `CHK("rst_status", 8'h00, o_status)
    repeat (4) @(negedge i_sys_clk);
    run_op(FWS_CMD_POLL);
    `CHK("rst_resume", RES_ACCEPTED, o_result)
    m_busy = 1'b0;
    $display("test mid-run reset done");
    close_out;
  end
  initial begin
    repeat (WD_CYC) @(posedge i_sys_clk);
    failures++;
    close_out;
  end
endmodule : fws_host_tb
`default_nettype wire
